// ### adcs_pkg.sv
`default_nettype none
package adcs_pkg;
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          POR_TIME_US   = 4000;
  localparam int          POR_CYCLES    = POR_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          OSC_HZ        = 307_200;
  localparam int          OSC_DIV       = CLK_HZ / OSC_HZ;
  localparam int          F0_IDLE_DIVS  = 4;
  localparam int          CONV_TICKS    = 20480;
  localparam int          ISCK_HALF     = 4;
  localparam logic [5:0]  OUT_BITS      = 6'h20;
  localparam logic [3:0]  CFG_BITS      = 4'hD;
  localparam int          CFG_W         = 13;
  localparam int          RES_W         = 30;
  localparam int          CFG_CH_MSB    = 12;
  localparam int          CFG_CH_LSB    = 8;
  localparam int          CFG_IM_BIT    = 7;
  localparam int          CFG_FA_BIT    = 6;
  localparam int          CFG_FB_BIT    = 5;
  localparam int          CFG_SPD_BIT   = 4;
  localparam logic [12:0] CFG_RESET     = 13'h0000;
  localparam logic [29:0] CODE_OVER     = 30'h30000000;
  localparam logic [29:0] CODE_UNDER    = 30'h00000000;
  localparam logic [1:0]  WORD_HEAD     = 2'h0;
  typedef enum logic [1:0] {ST_POR, ST_CONV, ST_SLEEP, ST_DIO} adcs_state_type;
endpackage
`default_nettype wire

// ### adcs_conv_if.sv
`timescale 1ns/1ns
`default_nettype none
interface adcs_conv_if;
  logic start;
  logic speed_2x;
  logic busy;
  logic done;
  logic abort;
  modport ctrl  (output start, output speed_2x, output abort, input busy, input done);
  modport timer (input start, input speed_2x, input abort, output busy, output done);
endinterface
`default_nettype wire

// ### adcs_conv_timer.sv
`timescale 1ns/1ns
`default_nettype none
module adcs_conv_timer #(
  parameter int CONV_LEN = adcs_pkg::CONV_TICKS,
  parameter int DIV      = adcs_pkg::OSC_DIV
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  input  wire logic  conversion_clock_select_pin,
  adcs_conv_if.timer cif
);
  import adcs_pkg::*;
  localparam int CW = $clog2(CONV_LEN + 1);
  localparam int DW = $clog2(DIV + 1);
  localparam int IDLE_LEN = F0_IDLE_DIVS * DIV;
  localparam int IW = $clog2(IDLE_LEN + 1);
  if (CONV_LEN < 2 || DIV < 1) begin : g_bad_param
    $error("adcs_conv_timer: conversion length or divider too small");
  end

  logic          f0_m, f0_s, f0_p;
  logic [DW-1:0] osc_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] lim;
  logic          busy_q, done_q;
  logic          tick;
  logic [IW-1:0] idle_q;
  logic          ext_act;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f0_m <= 1'b0;
      f0_s <= 1'b0;
      f0_p <= 1'b0;
    end else if (ce) begin
      f0_m <= conversion_clock_select_pin;
      f0_s <= f0_m;
      f0_p <= f0_s;
    end
  end

  // Internal oscillator, replaced by pin edges whenever the pin toggles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= '0;
    end else if (ce) begin
      osc_q <= (osc_q == DW'(DIV - 1)) ? '0 : osc_q + 1'b1;
    end
  end

  // Pin counts as a clock only while its edges keep coming; a static pin idles out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= IW'(IDLE_LEN);
    end else if (ce) begin
      if (f0_s ^ f0_p) begin
        idle_q <= '0;
      end else if (idle_q != IW'(IDLE_LEN)) begin
        idle_q <= idle_q + 1'b1;
      end
    end
  end

  assign ext_act = (idle_q != IW'(IDLE_LEN));
  assign tick    = ext_act ? (f0_s & ~f0_p) : (osc_q == DW'(DIV - 1));
  // Conversion length is CONV_LEN ticks, halved when speed_2x is set
  assign lim  = cif.speed_2x ? CW'(CONV_LEN / 2) : CW'(CONV_LEN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= '0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (cif.abort) begin
        busy_q <= 1'b0;
        cnt_q  <= '0;
      end else if (cif.start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q  <= '0;
      end else if (busy_q && tick) begin
        if (cnt_q == lim - 1'b1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign cif.busy = busy_q;
  assign cif.done = done_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  conv_pulse_a: assert property (ce && done_q |=> !done_q)
    else $error("done pulse longer than one cycle");
endmodule
`default_nettype wire

// ### adcs_serial_core.sv
`timescale 1ns/1ns
`default_nettype none
module adcs_serial_core #(
  parameter int POR_LEN   = adcs_pkg::POR_CYCLES,
  parameter int CONV_LEN  = adcs_pkg::CONV_TICKS,
  parameter int OSC_DIVP  = adcs_pkg::OSC_DIV,
  parameter int SCK_HALF  = adcs_pkg::ISCK_HALF
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      supply_ok,
  input  wire logic                      cs_n_pin,
  input  wire logic                      sck_in,
  output var  logic                      sck_out,
  output var  logic                      sck_oe_n,
  input  wire logic                      sdi_pin,
  output var  logic                      sdo_out,
  output var  logic                      sdo_oe_n,
  input  wire logic                      conversion_clock_select_pin,
  input  wire logic [adcs_pkg::RES_W-1:0] adc_code,
  input  wire logic                      adc_over,
  input  wire logic                      adc_under,
  output var  logic [adcs_pkg::CFG_W-1:0] conv_cfg,
  output var  logic                      conv_busy,
  output var  logic                      sleeping
);
  import adcs_pkg::*;
  localparam int PW = $clog2(POR_LEN + 1);
  localparam int HW = $clog2(SCK_HALF + 1);
  if (POR_LEN < 2 || SCK_HALF < 1) begin : g_bad_param
    $error("adcs_serial_core: reset length or clock half period too small");
  end

  adcs_conv_if cif ();

  adcs_conv_timer #(.CONV_LEN(CONV_LEN), .DIV(OSC_DIVP)) u_timer (
    .clk                         (clk),
    .rst_n                       (rst_n),
    .ce                          (ce),
    .conversion_clock_select_pin (conversion_clock_select_pin),
    .cif                         (cif.timer)
  );

  adcs_state_type   state_q, state_d;
  logic             cs_m, cs_s, cs_p;
  logic             sck_m, sck_s, sck_p;
  logic             sdi_m, sdi_s;
  logic             sup_m, sup_s;
  logic [PW-1:0]    por_q;
  logic             int_mode_q;
  logic [HW-1:0]    half_q;
  logic             isck_q;
  logic             i_tick;
  logic             rise, fall;
  logic [5:0]       rise_cnt_q;
  logic [3:0]       in_cnt_q;
  logic [CFG_W-1:0] cfg_sh_q;
  logic [CFG_W-1:0] cfg_q;
  logic [31:0]      out_q;
  logic             sdo_q, sdo_oe_n_q;
  logic             start_q;
  logic             in_dio;
  logic             cs_fall;

  // Two-stage synchronisers for every pin input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_m  <= 1'b1;
      cs_s  <= 1'b1;
      cs_p  <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_p <= 1'b0;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
      sup_m <= 1'b0;
      sup_s <= 1'b0;
    end else if (ce) begin
      cs_m  <= cs_n_pin;
      cs_s  <= cs_m;
      cs_p  <= cs_s;
      sck_m <= sck_in;
      sck_s <= sck_m;
      sck_p <= sck_s;
      sdi_m <= sdi_pin;
      sdi_s <= sdi_m;
      sup_m <= supply_ok;
      sup_s <= sup_m;
    end
  end

  assign cs_fall = cs_p & ~cs_s;
  assign in_dio  = (state_q == ST_DIO) && !cs_s;
  assign i_tick  = (half_q == HW'(SCK_HALF - 1));
  // Clock pin activity only counts while selected and in transfer
  assign rise = in_dio && (int_mode_q ? (i_tick && !isck_q)
                                      : (sck_s && !sck_p));
  assign fall = in_dio && (int_mode_q ? (i_tick && isck_q)
                                      : (!sck_s && sck_p));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_POR: begin
        if (por_q == PW'(POR_LEN - 1)) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (cif.done) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!cs_s) begin
          state_d = ST_DIO;
        end
      end
      ST_DIO: begin
        if (cs_s) begin
          state_d = (rise_cnt_q != 6'h00) ? ST_CONV : ST_SLEEP;
        end else if (fall && rise_cnt_q == OUT_BITS) begin
          state_d = ST_CONV;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_POR;
      start_q <= 1'b0;
    end else if (ce) begin
      if (!sup_s) begin
        state_q <= ST_POR;
        start_q <= 1'b0;
      end else begin
        state_q <= state_d;
        start_q <= (state_d == ST_CONV) && (state_q != ST_CONV);
      end
    end
  end

  // Power-on reset interval, restarted whenever the supply dips
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_q <= '0;
    end else if (ce) begin
      if (!sup_s || state_q != ST_POR) begin
        por_q <= '0;
      end else begin
        por_q <= por_q + 1'b1;
      end
    end
  end

  // Clock mode: pin low means host clock, floating high means own clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mode_q <= 1'b0;
    end else if (ce) begin
      if (state_q == ST_POR && por_q == PW'(POR_LEN - 1)) begin
        int_mode_q <= sck_s;
      end else if (cs_fall && state_q != ST_DIO) begin
        int_mode_q <= sck_s;
      end
    end
  end

  // Own serial clock, starts low so the first toggle is a rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= '0;
      isck_q <= 1'b0;
    end else if (ce) begin
      if (!(in_dio && int_mode_q)) begin
        half_q <= '0;
        isck_q <= 1'b0;
      end else if (i_tick) begin
        half_q <= '0;
        isck_q <= ~isck_q;
      end else begin
        half_q <= half_q + 1'b1;
      end
    end
  end

  // Bit counters and configuration capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt_q <= '0;
      in_cnt_q   <= '0;
      cfg_sh_q   <= CFG_RESET;
    end else if (ce) begin
      if (state_q != ST_DIO) begin
        rise_cnt_q <= '0;
        in_cnt_q   <= '0;
      end else if (rise) begin
        if (rise_cnt_q != OUT_BITS) begin
          rise_cnt_q <= rise_cnt_q + 1'b1;
        end
        if (in_cnt_q != CFG_BITS) begin
          cfg_sh_q <= {cfg_sh_q[CFG_W-2:0], sdi_s};
          in_cnt_q <= in_cnt_q + 1'b1;
        end
      end
    end
  end

  // Settings apply from the next conversion start; reset gives defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
    end else if (ce) begin
      if (!sup_s) begin
        cfg_q <= CFG_RESET;
      end else if (state_q == ST_DIO && state_d == ST_CONV && in_cnt_q == CFG_BITS) begin
        cfg_q <= cfg_sh_q;
      end
    end
  end

  // Result word loaded at conversion end, shifted on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
    end else if (ce) begin
      if (!sup_s) begin
        out_q <= '0;
      end else if (state_q == ST_CONV && cif.done) begin
        out_q <= {WORD_HEAD, adc_over  ? CODE_OVER  :
                             adc_under ? CODE_UNDER : adc_code};
      end else if (fall) begin
        out_q <= {out_q[30:0], 1'b1};
      end
    end
  end

  // Output pin: status during conversion and sleep, data during transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_q      <= 1'b1;
      sdo_oe_n_q <= 1'b1;
    end else if (ce) begin
      sdo_oe_n_q <= cs_s;
      unique case (state_q)
        ST_POR, ST_CONV: sdo_q <= 1'b1;
        ST_SLEEP:        sdo_q <= 1'b0;
        ST_DIO:          sdo_q <= fall ? out_q[30] : out_q[31];
      endcase
    end
  end

  assign sdo_out   = sdo_q;
  assign sdo_oe_n  = sdo_oe_n_q;
  assign sck_out   = isck_q;
  assign sck_oe_n  = !(in_dio && int_mode_q);
  assign cif.start = start_q;
  assign cif.abort = !sup_s;
  assign cif.speed_2x = cfg_q[CFG_SPD_BIT];
  assign conv_cfg  = cfg_q;
  assign conv_busy = cif.busy;
  assign sleeping  = (state_q == ST_SLEEP);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_dio_release;
    ce && sup_s && state_q == ST_DIO && cs_s;
  endsequence

  done_to_sleep_a: assert property (ce && sup_s && state_q == ST_CONV && cif.done
    |=> state_q == ST_SLEEP) else $error("no sleep after conversion end");
  hold_result_a: assert property (state_q == ST_SLEEP ##1 state_q == ST_SLEEP
    |-> $stable(out_q)) else $error("result changed during sleep");
  wake_dio_a: assert property (ce && sup_s && state_q == ST_SLEEP && !cs_s
    |=> state_q == ST_DIO) else $error("no wake on select");
  back_sleep_a: assert property (s_dio_release ##0 rise_cnt_q == 6'h00
    |=> state_q == ST_SLEEP) else $error("early release did not sleep");
  abort_conv_a: assert property (s_dio_release ##0 rise_cnt_q != 6'h00
    |=> state_q == ST_CONV && start_q) else $error("abort did not start conversion");
  sdo_fall_a: assert property (ce && state_q == ST_DIO && fall
    |=> sdo_q == $past(out_q[30])) else $error("output bit not updated on fall");
  hiz_sel_a: assert property (ce && cs_s |=> sdo_oe_n)
    else $error("output driven while deselected");
  busy_high_a: assert property (ce && !cs_s && state_q == ST_CONV |=> sdo_out)
    else $error("status not high during conversion");
  ready_low_a: assert property (ce && !cs_s && state_q == ST_SLEEP |=> !sdo_out)
    else $error("status not low after conversion");
endmodule
`default_nettype wire

// ### adcs_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module adcs_host_model (
  input  wire logic        clk,
  input  wire logic        sdo_line,
  input  wire logic        sck_line,
  output var  logic        cs_n,
  output var  logic        sck,
  output var  logic        sdi,
  output var  logic [31:0] word,
  output var  logic        word_vld,
  output var  logic        tail
);
  import adcs_pkg::*;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    word = 32'h0;
    word_vld = 1'b0;
    tail = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Clock held low at every select fall keeps the host-clock mode
  task automatic xfer(input int nrise, input logic [12:0] cfg);
    int k;
    cs_n <= 1'b0;
    tick(5);
    for (k = 0; k < nrise; k++) begin
      sdi <= cfg[12-(k%CFG_W)];
      tick(4);
      sck <= 1'b1;
      tick(4);
      word <= {word[30:0], sdo_line};
      sck <= 1'b0;
    end
    tick(6);
    tail <= sdo_line;
    word_vld <= (nrise == 32);
    tick(1);
    word_vld <= 1'b0;
    cs_n <= 1'b1;
    tick(1);
  endtask
  // Clock pin left high at select fall hands the clock to the device
  task automatic xfer_int(input logic [12:0] cfg);
    int   k;
    logic prev;
    sck <= 1'b1;
    tick(3);
    sdi <= cfg[12];
    cs_n <= 1'b0;
    prev = 1'b1;
    k = 0;
    while (k < 32) begin
      tick(1);
      if (sck_line && !prev) begin
        word <= {word[30:0], sdo_line};
        k++;
        sdi <= cfg[12-(k%CFG_W)];
      end
      prev = sck_line;
    end
    tick(6);
    tail <= sdo_line;
    word_vld <= 1'b1;
    tick(1);
    word_vld <= 1'b0;
    cs_n <= 1'b1;
    tick(2);
    sck <= 1'b0;
    tick(1);
  endtask
  task automatic peek(output logic s);
    cs_n <= 1'b0;
    tick(5);
    s = sdo_line;
    cs_n <= 1'b1;
    tick(5);
  endtask
  // Clock activity with select high, which the device must ignore
  task automatic noise();
    repeat (3) begin
      sck <= 1'b1;
      tick(4);
      sck <= 1'b0;
      tick(4);
    end
  endtask
endmodule
`default_nettype wire

// ### adcs_serial_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adcs_serial_core_tb;
  import adcs_pkg::*;
  logic        clk, rst_n, supply_ok, adc_over, adc_under, sdo_out, sdo_oe_n, s;
  logic        cs_n, sck, sdi, sleeping, conv_busy, word_vld, tail;
  logic        ce, f0_run, sck_out, sck_oe_n;
  logic        last_q = 1'b0;
  logic        f0 = 1'b0;
  logic [29:0] adc_code;
  logic [12:0] conv_cfg, cfg_q;
  logic [31:0] word, rng;
  logic [31:0] exp_q[$];
  int          error_cnt, tests_run;
  int          cyc = 0;
  wire logic   sdo_line = sdo_oe_n ? ~last_q : sdo_out;
  wire logic   sck_line = sck_oe_n ? sck : sck_out;

  adcs_serial_core #(.POR_LEN(20), .CONV_LEN(8), .OSC_DIVP(2)) u_adcs_serial_core (
    .clk(clk), .rst_n(rst_n), .ce(ce), .supply_ok(supply_ok), .cs_n_pin(cs_n),
    .sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .sdi_pin(sdi), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .conversion_clock_select_pin(f0), .adc_code(adc_code),
    .adc_over(adc_over), .adc_under(adc_under), .conv_cfg(conv_cfg),
    .conv_busy(conv_busy), .sleeping(sleeping));

  adcs_host_model u_adcs_host_model (
    .clk(clk), .sdo_line(sdo_line), .sck_line(sck_line), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .word(word), .word_vld(word_vld), .tail(tail));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Status bit, zero bit, then the clamped or plain 30-bit result
  function automatic logic [31:0] expw();
    return {2'b00, adc_over ? 30'h30000000 : adc_under ? 30'h00000000 : adc_code};
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wait_sig(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      $display("[ERR] wait_sig expected 1 seen %b", sig);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (f0_run && cyc % 4 == 0) begin
      f0 <= ~f0;
    end
    if (!sdo_oe_n) begin
      last_q <= sdo_out;
    end
    if (word_vld) begin
      chk("word", exp_q.size() ? exp_q.pop_front() : 32'hX, word);
    end
    if (cyc == 12000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    int i;
    rst_n = 1'b0;
    supply_ok = 1'b0;
    adc_code = 30'h0;
    adc_over = 1'b0;
    adc_under = 1'b0;
    ce = 1'b1;
    f0_run = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    rng = 32'h00013E34;
    repeat (10) @(posedge clk);
    chk("oe_rst", 1, sdo_oe_n);
    rst_n <= 1'b1;
    supply_ok <= 1'b1;
    wait_sig(conv_busy);
    u_adcs_host_model.peek(s);
    chk("busy_status", 1, s);
    wait_sig(sleeping);
    chk("sleep", 1, sleeping);
    chk("cfg_por", 0, conv_cfg);
    u_adcs_host_model.peek(s);
    chk("done_status", 0, s);
    u_adcs_host_model.noise();
    chk("sleep_noise", 1, sleeping);
    chk("oe_noise", 1, sdo_oe_n);
    for (i = 0; i < 6; i++) begin
      rng = xs(rng);
      cfg_q = rng[12:0];
      exp_q.push_back(expw());
      u_adcs_host_model.xfer(32, cfg_q);
      chk("tail", 1, tail);
      chk("cfg", cfg_q, conv_cfg);
      rng = xs(rng);
      adc_code <= rng[29:0];
      adc_over <= (i == 1);
      adc_under <= (i == 2);
      wait_sig(sleeping);
    end
    u_adcs_host_model.peek(s);
    chk("held_status", 0, s);
    repeat (40) @(posedge clk);
    exp_q.push_back(expw());
    u_adcs_host_model.xfer(32, cfg_q);
    wait_sig(sleeping);
    adc_code <= ~adc_code;
    u_adcs_host_model.xfer(5, ~cfg_q);
    repeat (5) @(posedge clk);
    chk("abort_busy", 1, conv_busy);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    chk("freeze_busy", 1, conv_busy);
    ce <= 1'b1;
    chk("cfg_keep", cfg_q, conv_cfg);
    wait_sig(sleeping);
    exp_q.push_back(expw());
    cfg_q[CFG_SPD_BIT] = 1'b0;
    f0_run <= 1'b1;
    u_adcs_host_model.xfer(32, cfg_q);
    repeat (20) @(posedge clk);
    chk("ext_clk_busy", 1, conv_busy);
    wait_sig(sleeping);
    f0_run <= 1'b0;
    rng = xs(rng);
    cfg_q = rng[12:0];
    exp_q.push_back(expw());
    u_adcs_host_model.xfer_int(cfg_q);
    chk("tail_int", 1, tail);
    chk("cfg_int", cfg_q, conv_cfg);
    chk("sck_rel", 1, sck_oe_n);
    supply_ok <= 1'b0;
    repeat (5) @(posedge clk);
    chk("cfg_low", 0, conv_cfg);
    chk("busy_low", 0, conv_busy);
    supply_ok <= 1'b1;
    rng = xs(rng);
    adc_code <= rng[29:0];
    wait_sig(sleeping);
    chk("cfg_por2", 0, conv_cfg);
    rng = xs(rng);
    cfg_q = rng[12:0];
    exp_q.push_back(expw());
    u_adcs_host_model.xfer(32, cfg_q);
    chk("cfg_first", cfg_q, conv_cfg);
    chk("exp_left", 0, exp_q.size());
    end_sim();
  end
endmodule
`default_nettype wire
